/* File: common/pfc_map.vh */
`ifndef PFC_MAP_VH
`define PFC_MAP_VH
// Timing
`define PFC_CLK_HZ      50000000
`define PFC_TICK_US     1000
`define PFC_TICK_CYC    ((`PFC_CLK_HZ / 1000000) * `PFC_TICK_US)
// Register byte offsets
`define PFC_A_CTRL      8'h00
`define PFC_A_RATIO     8'h04
`define PFC_A_RAMP_UP   8'h08
`define PFC_A_RAMP_DN   8'h0C
`define PFC_A_BIAS      8'h10
`define PFC_A_KP        8'h14
`define PFC_A_TI        8'h18
`define PFC_A_TD        8'h1C
`define PFC_A_DLAG      8'h20
`define PFC_A_ENGAGE    8'h24
`define PFC_A_IUPPER    8'h28
`define PFC_A_ILOWER    8'h2C
`define PFC_A_DB_A      8'h30
`define PFC_A_DB_B      8'h34
`define PFC_A_SCALE_A   8'h38
`define PFC_A_SCALE_B   8'h3C
`define PFC_A_KINK      8'h40
`define PFC_A_TRIM      8'h44
`define PFC_A_SETP      8'h48
`define PFC_A_STATUS    8'h4C
`define PFC_A_PDIFF     8'h50
`define PFC_A_CPOUT     8'h54
`define PFC_A_VALVE     8'h58
`define PFC_A_SPRAMP    8'h5C
// Control register fields
`define PFC_B_INVERT    0
`define PFC_B_HOLD      1
`define PFC_B_PROFILE   2
`define PFC_B_ENABLE    3
`define PFC_W_CTRL      4
// Reset values
`define PFC_R_RATIO     24'h000064
`define PFC_R_RAMP      24'h0003E8
`define PFC_R_KP        24'h000100
`define PFC_R_DLAG      24'h000005
`define PFC_R_IUPPER    24'h002710
`define PFC_R_ILOWER    24'hFFD8F0
`define PFC_R_SCALE     24'h002710
// Scaling and limits
`define PFC_PCT_FULL    10000
`define PFC_FS_SHIFT    19
`define PFC_RAMP_SPAN   40'h0000080000
`define PFC_BAR10_MBAR  100
`define PFC_RATIO_ONE   100
`define PFC_RATIO_MIN   24'h000005
`define PFC_RATIO_MAX   24'h0007D0
`define PFC_KP_SHIFT    8
`define PFC_TENTHS      10
`define PFC_PERMILLE    1000
`define PFC_DIV_STEPS   40
`define PFC_LAST_JOB    3'h5
`endif

/* File: core/pfc_pressure_ctrl.v */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.vh"

module pfc_pressure_ctrl #(
	parameter TICK_CYCLES = `PFC_TICK_CYC
) (
	input  wire               ref_clk,           // System clock, 50 MHz
	input  wire               rst,               // Asynchronous reset, active high
	input  wire               psel,              // APB select
	input  wire               penable,           // APB access phase
	input  wire               pwrite,            // APB direction
	input  wire [7:0]         paddr,             // APB byte address
	input  wire [31:0]        pwdata,            // APB write data
	output reg  [31:0]        prdata,            // APB read data
	output reg                pready,            // APB ready
	output reg                pslverr,           // APB error on unmapped address
	input  wire [15:0]        pressure_sensor_a, // Port A pressure, 0.1 bar
	input  wire [15:0]        pressure_sensor_b, // Port B pressure, 0.1 bar
	input  wire signed [15:0] pos_ctrl_out,      // Position loop output, 0.01 %
	output reg  signed [15:0] valve_drive,       // Valve drive, 0.01 %
	output reg                profile_hold       // Halts the profile generator
);

	localparam S_IDLE  = 2'h0;
	localparam S_LOAD  = 2'h1;
	localparam S_DIV   = 2'h2;
	localparam S_STORE = 2'h3;
	localparam signed [31:0] PCT = `PFC_PCT_FULL;
	localparam [23:0] RATIO_ONE24 = `PFC_RATIO_ONE;
	localparam [23:0] TENTHS24    = `PFC_TENTHS;

	// Software registers
	reg [`PFC_W_CTRL-1:0] ctrl_r;
	reg [23:0] ratio_r, ramp_up_r, ramp_dn_r, kp_r, ti_r, td_r, dlag_r, engage_r;
	reg [23:0] db_a_r, db_b_r, scale_a_r, scale_b_r, kink_r;
	reg signed [23:0] bias_r, iup_r, ilow_r, trim_r, setp_r;
	// Loop state
	reg [15:0] sa_m_r, sa_r, sb_m_r, sb_r;
	reg [1:0]  state_r;
	reg [2:0]  job_r;
	reg [5:0]  step_r;
	reg [31:0] tick_r;
	reg [39:0] quo_r;
	reg [24:0] rem_r;
	reg [23:0] den_r;
	reg signed [31:0] pact_r, sp_r, p_r, p_prev_r, i_r, draw_r, df_r, cmd_r, pdiff_r, cp_r;
	reg        takeover_r;

	wire       invert  = ctrl_r[`PFC_B_INVERT];
	wire       run_pid = ctrl_r[`PFC_B_ENABLE];
	wire [31:0] pa_mbar = sa_r * `PFC_BAR10_MBAR;
	wire [31:0] pb_mbar = sb_r * `PFC_BAR10_MBAR;
	wire       big_a   = ratio_r >= `PFC_RATIO_ONE;
	wire       rising  = setp_r > sp_r;

	// Loop error and proportional part, error scaled to 0.01 % of span
	wire signed [31:0] err    = sp_r - pact_r;
	wire signed [63:0] err_w  = err * PCT;
	wire signed [31:0] err_pc = err_w[`PFC_FS_SHIFT+31:`PFC_FS_SHIFT];
	wire signed [63:0] p_w    = err_pc * $signed({8'h00, kp_r});
	wire signed [31:0] p_new  = p_w[`PFC_KP_SHIFT+31:`PFC_KP_SHIFT];
	wire signed [31:0] dp     = p_r - p_prev_r;
	wire signed [31:0] dd     = draw_r - df_r;
	wire signed [31:0] ctl_mag = cmd_r[31] ? -cmd_r : cmd_r;
	wire [23:0] db_sel    = cmd_r[31] ? db_b_r : db_a_r;
	wire [23:0] scale_sel = cmd_r[31] ? scale_b_r : scale_a_r;
	wire        low_seg   = ctl_mag[23:0] < kink_r;

	function [31:0] absv;
		input signed [31:0] v;
		begin
			absv = v[31] ? -v : v;
		end
	endfunction

	// Divider job operands; each job is one stage of the per-tick pipeline
	reg [63:0] jn;
	reg [23:0] jd;
	always @* begin
		jn = 64'h0;
		jd = 24'h1;
		case (job_r)
			3'h0: begin
				jn = big_a ? pb_mbar * `PFC_RATIO_ONE : pa_mbar * ratio_r;
				jd = big_a ? ratio_r : RATIO_ONE24;
			end
			3'h1: begin
				jn = {24'h0, `PFC_RAMP_SPAN};
				jd = rising ? ramp_up_r : ramp_dn_r;
			end
			3'h2: begin
				jn = absv(p_r) * `PFC_TENTHS;
				jd = (ti_r == 24'h0) ? 24'h1 : ti_r;
			end
			3'h3: begin
				jn = absv(dp) * td_r;
				jd = TENTHS24;
			end
			3'h4: begin
				jn = absv(dd) * `PFC_TENTHS;
				jd = dlag_r + TENTHS24;
			end
			3'h5: begin
				jn = low_seg ? ctl_mag * db_sel : (ctl_mag - kink_r) * (scale_sel - db_sel);
				jd = low_seg ? kink_r : PCT[23:0] - kink_r;
			end
			default: begin
				jn = 64'h0;
				jd = 24'h1;
			end
		endcase
	end

	// Restoring divider step
	wire [24:0] rem_sh = {rem_r[23:0], quo_r[39]};
	wire        fits   = rem_sh >= {1'b0, den_r};
	wire signed [31:0] q = quo_r[31:0];

	// Stage results that depend on the quotient
	wire signed [31:0] ab_q   = big_a ? $signed(pa_mbar) - q : q - $signed(pb_mbar);
	wire signed [31:0] pd_new = invert ? -ab_q : ab_q;
	wire signed [31:0] sp_up  = (sp_r + q > setp_r) ? setp_r : sp_r + q;
	wire signed [31:0] sp_dn  = (sp_r - q < setp_r) ? setp_r : sp_r - q;
	wire signed [31:0] inc    = p_r[31] ? -q : q;
	wire signed [47:0] eng_l  = pact_r * `PFC_PERMILLE;
	wire signed [47:0] eng_r  = sp_r * $signed({8'h00, engage_r});
	wire        i_on   = (ti_r != 24'h0) && ((engage_r == 24'h0) || (eng_l >= eng_r));
	wire signed [31:0] i_sum  = i_r + inc;
	wire signed [31:0] i_cl   = (i_sum > iup_r) ? iup_r : (i_sum < ilow_r) ? ilow_r : i_sum;
	wire signed [31:0] df_new = dd[31] ? df_r - q : df_r + q;
	wire signed [31:0] pid    = p_r + i_r + df_new;
	wire signed [31:0] pid_s  = (pid > PCT) ? PCT : (pid < -PCT) ? -PCT : pid;
	wire signed [31:0] cp     = (pid_s < ilow_r) ? ilow_r : pid_s;
	wire signed [31:0] cpv    = invert ? -cp : cp;
	wire signed [31:0] pos    = pos_ctrl_out;
	wire        take   = run_pid && (invert ? (cpv > pos) : (cpv < pos));
	wire signed [31:0] mrg    = take ? cpv : pos;
	wire signed [31:0] mrg_s  = (mrg > PCT) ? PCT : (mrg < -PCT) ? -PCT : mrg;
	wire signed [31:0] shp    = (ctl_mag == 0) ? 0 : low_seg ? q : $signed({8'h00, db_sel}) + q;
	wire signed [31:0] vout   = (cmd_r[31] ? -shp : shp) + trim_r;
	wire signed [31:0] vout_s = (vout > PCT) ? PCT : (vout < -PCT) ? -PCT : vout;

	// Pressure pins come from outside the clock domain: two flops each
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sa_m_r <= 16'h0000;
			sa_r   <= 16'h0000;
			sb_m_r <= 16'h0000;
			sb_r   <= 16'h0000;
		end else begin
			sa_m_r <= pressure_sensor_a;
			sa_r   <= sa_m_r;
			sb_m_r <= pressure_sensor_b;
			sb_r   <= sb_m_r;
		end
	end

	// Control tick sequencer; one shared divider keeps the area small
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r    <= S_IDLE;
			job_r      <= 3'h0;
			step_r     <= 6'h00;
			tick_r     <= 32'h0;
			quo_r      <= 40'h0;
			rem_r      <= 25'h0;
			den_r      <= 24'h1;
			pdiff_r    <= 32'h0;
			pact_r     <= 32'h0;
			sp_r       <= 32'h0;
			p_r        <= 32'h0;
			p_prev_r   <= 32'h0;
			i_r        <= 32'h0;
			draw_r     <= 32'h0;
			df_r       <= 32'h0;
			cmd_r      <= 32'h0;
			cp_r       <= 32'h0;
			takeover_r <= 1'b0;
			valve_drive  <= 16'sh0000;
			profile_hold <= 1'b0;
		end else begin
			tick_r <= (tick_r >= TICK_CYCLES - 1) ? 32'h0 : tick_r + 32'h1;
			case (state_r)
				S_IDLE: begin
					job_r <= 3'h0;
					if (tick_r == 32'h0)
						state_r <= S_LOAD;
				end
				S_LOAD: begin
					den_r   <= jd;
					quo_r   <= jn[39:0];
					rem_r   <= 25'h0;
					step_r  <= 6'h00;
					state_r <= S_DIV;
				end
				S_DIV: begin
					rem_r  <= fits ? rem_sh - {1'b0, den_r} : rem_sh;
					quo_r  <= {quo_r[38:0], fits};
					step_r <= step_r + 6'h01;
					if (step_r == `PFC_DIV_STEPS - 1)
						state_r <= S_STORE;
				end
				S_STORE: begin
					case (job_r)
						3'h0: begin
							pdiff_r <= pd_new;
							pact_r  <= pd_new + bias_r;
						end
						3'h1: begin
							sp_r     <= rising ? sp_up : sp_dn;
							p_prev_r <= p_r;
						end
						3'h2: begin
							p_r <= p_new;
							if (i_on)
								i_r <= i_cl;
						end
						3'h3: draw_r <= dp[31] ? -q : q;
						3'h4: begin
							df_r       <= df_new;
							cp_r       <= cpv;
							takeover_r <= take;
							cmd_r      <= mrg_s;
							profile_hold <= take && ctrl_r[`PFC_B_HOLD] && ctrl_r[`PFC_B_PROFILE];
						end
						3'h5: valve_drive <= vout_s[15:0];
						default: valve_drive <= valve_drive;
					endcase
					job_r   <= job_r + 3'h1;
					state_r <= (job_r == `PFC_LAST_JOB) ? S_IDLE : S_LOAD;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// APB slave: one wait state so read data and ready come from flops
	wire acc = psel && penable;
	reg  [31:0] rd_mux;
	reg         hit;
	always @* begin
		hit    = 1'b1;
		rd_mux = 32'h0;
		case (paddr)
			`PFC_A_CTRL:    rd_mux = {28'h0, ctrl_r};
			`PFC_A_RATIO:   rd_mux = {8'h0, ratio_r};
			`PFC_A_RAMP_UP: rd_mux = {8'h0, ramp_up_r};
			`PFC_A_RAMP_DN: rd_mux = {8'h0, ramp_dn_r};
			`PFC_A_BIAS:    rd_mux = {{8{bias_r[23]}}, bias_r};
			`PFC_A_KP:      rd_mux = {8'h0, kp_r};
			`PFC_A_TI:      rd_mux = {8'h0, ti_r};
			`PFC_A_TD:      rd_mux = {8'h0, td_r};
			`PFC_A_DLAG:    rd_mux = {8'h0, dlag_r};
			`PFC_A_ENGAGE:  rd_mux = {8'h0, engage_r};
			`PFC_A_IUPPER:  rd_mux = {{8{iup_r[23]}}, iup_r};
			`PFC_A_ILOWER:  rd_mux = {{8{ilow_r[23]}}, ilow_r};
			`PFC_A_DB_A:    rd_mux = {8'h0, db_a_r};
			`PFC_A_DB_B:    rd_mux = {8'h0, db_b_r};
			`PFC_A_SCALE_A: rd_mux = {8'h0, scale_a_r};
			`PFC_A_SCALE_B: rd_mux = {8'h0, scale_b_r};
			`PFC_A_KINK:    rd_mux = {8'h0, kink_r};
			`PFC_A_TRIM:    rd_mux = {{8{trim_r[23]}}, trim_r};
			`PFC_A_SETP:    rd_mux = {{8{setp_r[23]}}, setp_r};
			`PFC_A_STATUS:  rd_mux = {30'h0, profile_hold, takeover_r};
			`PFC_A_PDIFF:   rd_mux = pdiff_r;
			`PFC_A_CPOUT:   rd_mux = cp_r;
			`PFC_A_VALVE:   rd_mux = {{16{valve_drive[15]}}, valve_drive};
			`PFC_A_SPRAMP:  rd_mux = sp_r;
			default:        hit = 1'b0;
		endcase
	end

	// Ratio and ramp times are clamped so the divider never sees zero
	wire [23:0] wr_ratio = (pwdata[23:0] < `PFC_RATIO_MIN) ? `PFC_RATIO_MIN :
		(pwdata[23:0] > `PFC_RATIO_MAX) ? `PFC_RATIO_MAX : pwdata[23:0];
	wire [23:0] wr_ramp  = (pwdata[23:0] == 24'h0) ? 24'h1 : pwdata[23:0];
	wire        do_wr    = acc && pready && pwrite && hit;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata    <= 32'h0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			ctrl_r    <= 4'h0;
			ratio_r   <= `PFC_R_RATIO;
			ramp_up_r <= `PFC_R_RAMP;
			ramp_dn_r <= `PFC_R_RAMP;
			bias_r    <= 24'sh0;
			kp_r      <= `PFC_R_KP;
			ti_r      <= 24'h0;
			td_r      <= 24'h0;
			dlag_r    <= `PFC_R_DLAG;
			engage_r  <= 24'h0;
			iup_r     <= `PFC_R_IUPPER;
			ilow_r    <= `PFC_R_ILOWER;
			db_a_r    <= 24'h0;
			db_b_r    <= 24'h0;
			scale_a_r <= `PFC_R_SCALE;
			scale_b_r <= `PFC_R_SCALE;
			kink_r    <= 24'h0;
			trim_r    <= 24'sh0;
			setp_r    <= 24'sh0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !hit;
			if (acc && !pready)
				prdata <= pwrite ? 32'h0 : rd_mux;
			if (do_wr) begin
				case (paddr)
					`PFC_A_CTRL:    ctrl_r    <= pwdata[`PFC_W_CTRL-1:0];
					`PFC_A_RATIO:   ratio_r   <= wr_ratio;
					`PFC_A_RAMP_UP: ramp_up_r <= wr_ramp;
					`PFC_A_RAMP_DN: ramp_dn_r <= wr_ramp;
					`PFC_A_BIAS:    bias_r    <= pwdata[23:0];
					`PFC_A_KP:      kp_r      <= pwdata[23:0];
					`PFC_A_TI:      ti_r      <= pwdata[23:0];
					`PFC_A_TD:      td_r      <= pwdata[23:0];
					`PFC_A_DLAG:    dlag_r    <= pwdata[23:0];
					`PFC_A_ENGAGE:  engage_r  <= pwdata[23:0];
					`PFC_A_IUPPER:  iup_r     <= pwdata[23:0];
					`PFC_A_ILOWER:  ilow_r    <= pwdata[23:0];
					`PFC_A_DB_A:    db_a_r    <= pwdata[23:0];
					`PFC_A_DB_B:    db_b_r    <= pwdata[23:0];
					`PFC_A_SCALE_A: scale_a_r <= pwdata[23:0];
					`PFC_A_SCALE_B: scale_b_r <= pwdata[23:0];
					`PFC_A_KINK:    kink_r    <= pwdata[23:0];
					`PFC_A_TRIM:    trim_r    <= pwdata[23:0];
					`PFC_A_SETP:    setp_r    <= pwdata[23:0];
					default:        ctrl_r    <= ctrl_r;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* File: testbench/pfc_plant.sv */
`timescale 1ns/1ps
`default_nettype none
// Stands in for the two port pressure sensors and the valve amplifier
module pfc_plant (
	input  wire logic               ref_clk,           // Clock
	input  wire logic               rst,               // Reset, active high
	input  wire logic [15:0]        press_a_set,       // Wanted port A pressure
	input  wire logic [15:0]        press_b_set,       // Wanted port B pressure
	input  wire logic signed [15:0] valve_drive,       // Drive into the amplifier
	output var  logic [15:0]        pressure_sensor_a, // Port A sensor
	output var  logic [15:0]        pressure_sensor_b  // Port B sensor
);
	logic signed [15:0] coil_r;
	// Sensors update on the clock; the amplifier latches the drive it sees
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pressure_sensor_a <= 16'h0000;
			pressure_sensor_b <= 16'h0000;
			coil_r <= 16'sh0000;
		end else begin
			pressure_sensor_a <= press_a_set;
			pressure_sensor_b <= press_b_set;
			coil_r <= valve_drive;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/pfc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module pfc_chk #(
	parameter TICK_CYCLES = 400
) (
	input wire logic               ref_clk,           // Clock
	input wire logic               rst,               // Reset
	input wire logic               psel,              // APB select
	input wire logic               penable,           // APB enable
	input wire logic               pwrite,            // APB direction
	input wire logic [7:0]         paddr,             // APB address
	input wire logic [31:0]        pwdata,            // APB write data
	input wire logic [31:0]        prdata,            // APB read data
	input wire logic               pready,            // APB ready
	input wire logic               pslverr,           // APB error
	input wire logic [15:0]        pressure_sensor_a, // Port A
	input wire logic [15:0]        pressure_sensor_b, // Port B
	input wire logic signed [15:0] pos_ctrl_out,      // Position loop
	input wire logic signed [15:0] valve_drive,       // Valve output
	input wire logic               profile_hold       // Profile halt
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [15:0] gap_r;
	// Cycles since the valve output moved; parked high so reset never trips it
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			gap_r <= 16'hFFFF;
		else if ($changed(valve_drive))
			gap_r <= 16'h0001;
		else if (gap_r != 16'hFFFF)
			gap_r <= gap_r + 16'h0001;
	end
	property p_ready_pulse; pready |=> !pready; endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_ready_access; pready |-> psel && penable; endproperty
	a_ready_access: assert property (p_ready_access) else $error("ready outside access");
	property p_one_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
	a_one_wait: assert property (p_one_wait) else $error("answer not after one wait");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_unmapped; pready && paddr > 8'h5C |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_mapped; pready && paddr <= 8'h5C && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_err_rdata; pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
	a_err_rdata: assert property (p_err_rdata) else $error("refused read data not zero");
	property p_valve_range; valve_drive <= 16'sh2710 && valve_drive >= -16'sh2710; endproperty
	a_valve_range: assert property (p_valve_range) else $error("valve beyond range");
	property p_valve_tick; $changed(valve_drive) |-> gap_r >= TICK_CYCLES / 2; endproperty
	a_valve_tick: assert property (p_valve_tick) else $error("valve moved twice a tick");
	property p_hold_steady; $changed(profile_hold) |=> $stable(profile_hold) [*8]; endproperty
	a_hold_steady: assert property (p_hold_steady) else $error("hold glitch");
endmodule
bind pfc_pressure_ctrl pfc_chk #(.TICK_CYCLES(TICK_CYCLES)) i_pfc_chk (
	.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pressure_sensor_a(pressure_sensor_a), .pressure_sensor_b(pressure_sensor_b),
	.pos_ctrl_out(pos_ctrl_out), .valve_drive(valve_drive), .profile_hold(profile_hold)
);
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.vh"
module testbench;
	localparam int TICK = 400;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr, profile_hold;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [15:0] pa = 16'h0, pb = 16'h0, sens_a, sens_b;
	logic signed [15:0] pos = 16'sh0000, valve_drive;
	int errors = 0, n_checks = 0;
	// Short tick keeps the run small; expectations use the same value
	pfc_pressure_ctrl #(.TICK_CYCLES(TICK)) i_pfc_pressure_ctrl (.ref_clk(ref_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pressure_sensor_a(sens_a), .pressure_sensor_b(sens_b), .pos_ctrl_out(pos),
		.valve_drive(valve_drive), .profile_hold(profile_hold));
	pfc_plant i_pfc_plant (.ref_clk(ref_clk), .rst(rst), .press_a_set(pa), .press_b_set(pb),
		.valve_drive(valve_drive), .pressure_sensor_a(sens_a), .pressure_sensor_b(sens_b));
	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;
	task results;
		if (errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer, entered just after an edge; a spare edge follows so psel is not
	// assigned twice in one step by back-to-back calls
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
	task rd(input logic [7:0] a, input logic [31:0] e); apb(1'b0, a, 32'h0); chk(rdat, e); endtask
	task ticks(input int n); repeat (n * TICK) @(posedge ref_clk); endtask
	function logic [31:0] vd(); return {{16{valve_drive[15]}}, valve_drive}; endfunction
	task sv(input logic [15:0] p, input logic [31:0] e); pos <= p; ticks(3); chk(vd(), e); endtask
	task poll(input logic [31:0] old);
		for (int k = 0; k < 200; k++) begin
			apb(1'b0, `PFC_A_SPRAMP, 32'h0);
			if (rdat !== old) break;
		end
	endtask
	// Reset values, clamping on write, read-only and unmapped places
	task t_regs;
		rd(`PFC_A_RATIO, 32'h64);
		rd(`PFC_A_RAMP_UP, 32'h3E8);
		rd(`PFC_A_KP, 32'h100);
		rd(`PFC_A_DLAG, 32'h5);
		rd(`PFC_A_ILOWER, 32'hFFFFD8F0);
		rd(`PFC_A_IUPPER, 32'h2710);
		rd(`PFC_A_SCALE_B, 32'h2710);
		wr(`PFC_A_RATIO, 32'h1); rd(`PFC_A_RATIO, 32'h5);
		wr(`PFC_A_RATIO, 32'hBB8); rd(`PFC_A_RATIO, 32'h7D0);
		wr(`PFC_A_RAMP_DN, 32'h0); rd(`PFC_A_RAMP_DN, 32'h1);
		wr(`PFC_A_VALVE, 32'h1234); rd(`PFC_A_VALVE, 32'h0);
		wr(8'h60, 32'h5); chk(rerr, 1'b1);
		rd(8'h60, 32'h0); chk(rerr, 1'b1);
		wr(`PFC_A_RATIO, 32'h64);
	endtask
	// Pseudo pressure sign, inversion and area ratio
	task t_pdiff;
		pa <= 16'h64; pb <= 16'h32; ticks(3);
		rd(`PFC_A_PDIFF, 32'h1388);
		wr(`PFC_A_CTRL, 32'h1); ticks(3);
		rd(`PFC_A_PDIFF, 32'hFFFFEC78);
		wr(`PFC_A_CTRL, 32'h0); wr(`PFC_A_RATIO, 32'hC8); ticks(3);
		rd(`PFC_A_PDIFF, 32'h1D4C);
		wr(`PFC_A_RATIO, 32'h64); pa <= 16'h0; pb <= 16'h0;
	endtask
	// Output saturation, trim and kinked shaping with the pressure loop off
	task t_shape;
		sv(16'h4E20, 32'h2710);
		sv(16'hB1E0, 32'hFFFFD8F0);
		wr(`PFC_A_TRIM, 32'h32); sv(16'h1388, 32'h13BA);
		wr(`PFC_A_TRIM, 32'h0); wr(`PFC_A_DB_A, 32'h7D0);
		wr(`PFC_A_DB_B, 32'hBB8); wr(`PFC_A_KINK, 32'h3E8);
		sv(16'h01F4, 32'h3E8);
		sv(16'h157C, 32'h1770);
		sv(16'hFE0C, 32'hFFFFFA24);
		wr(`PFC_A_DB_A, 32'h0); wr(`PFC_A_DB_B, 32'h0); wr(`PFC_A_KINK, 32'h0);
	endtask
	// Min merge takeover, profile hold, floor at zero, max merge when inverted
	task t_merge;
		wr(`PFC_A_BIAS, 32'h8000); wr(`PFC_A_CTRL, 32'hE);
		sv(16'h1388, 32'hFFFFFD8F);
		rd(`PFC_A_CPOUT, 32'hFFFFFD8F);
		rd(`PFC_A_STATUS, 32'h3);
		chk(profile_hold, 1'b1);
		ticks(2); chk(vd(), 32'hFFFFFD8F);
		wr(`PFC_A_ILOWER, 32'h0); ticks(3); chk(vd(), 32'h0);
		wr(`PFC_A_ILOWER, 32'hFFFFD8F0); wr(`PFC_A_CTRL, 32'hF);
		sv(16'hF448, 32'h271);
		wr(`PFC_A_CTRL, 32'hE); wr(`PFC_A_BIAS, 32'hFFFF8000);
		sv(16'h01F4, 32'h1F4);
		chk(profile_hold, 1'b0);
	endtask
	// Separate rise and fall ramp rates of the setpoint
	task t_ramp;
		wr(`PFC_A_BIAS, 32'h0); wr(`PFC_A_CTRL, 32'h8);
		wr(`PFC_A_RAMP_UP, 32'h8); wr(`PFC_A_RAMP_DN, 32'h10);
		wr(`PFC_A_SETP, 32'h186A0); poll(32'h0);
		chk(rdat, 32'h10000);
		ticks(3); rd(`PFC_A_SPRAMP, 32'h186A0);
		wr(`PFC_A_SETP, 32'h0); poll(32'h186A0);
		chk(rdat, 32'h106A0);
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_regs;
		t_pdiff;
		t_shape;
		t_merge;
		t_ramp;
		results;
	end
	// Watchdog against a hung handshake
	initial begin
		repeat (80000) @(posedge ref_clk);
		errors++;
		results;
	end
endmodule
`default_nettype wire
